// ### verilog/cmb_defs.svh
`ifndef CMB_DEFS_SVH
`define CMB_DEFS_SVH
// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define CMB_IDX_ID0 5'h00
`define CMB_IDX_ID1 5'h01
`define CMB_IDX_ID2 5'h02
`define CMB_IDX_ID3 5'h03
`define CMB_IDX_PAY0 5'h04
`define CMB_IDX_PAY7 5'h0B
`define CMB_IDX_LEN 5'h0C
`define CMB_IDX_CTRL 5'h10
`define CMB_IDX_STAT 5'h11
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CMB_ID1_RTR 4
`define CMB_ID1_IDE 3
`define CMB_CTRL_START 0
`define CMB_CTRL_ARM 1
`define CMB_CTRL_CLR 2
// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define CMB_REG_RST 8'h00
`define CMB_DLC_MAX 4'h8
`define CMB_HDR_LAST 5'h10
`define CMB_ARB_BITS 5'h0C
`define CMB_RESP_OKAY 2'h0
`define CMB_RESP_DECERR 2'h3
`endif

// ### verilog/cmb_pkg.sv
// ----------------------------------------------------------------
// shared types
// ----------------------------------------------------------------
package cmb_pkg;
  // transmit serializer phases
  typedef enum logic [1:0] {TX_IDLE, TX_HDR, TX_WAIT, TX_DATA} cmb_tx_state_type;
  // one buffer byte
  typedef logic [7:0] cmb_byte_type;
endpackage

// ### verilog/cmb_msg_buffer.sv
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "cmb_defs.svh"

// ----------------------------------------------------------------
// payload fifo
// ----------------------------------------------------------------
module cmb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_flush,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  // storage words
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  // pointers carry one extra wrap bit
  logic [AW:0] wptr;
  logic [AW:0] rptr;
  logic push;
  logic pop;

  // full when wrap bits differ and indices match
  assign o_in_ready = !((wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]));
  assign o_out_valid = (wptr != rptr);
  assign o_out_data = mem[rptr[AW-1:0]];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // word store
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem[wptr[AW-1:0]] <= i_in_data;
    end
  end

  // write pointer
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || i_flush) begin
      wptr <= '0;
    end else if (push) begin
      wptr <= wptr + 1'b1;
    end
  end

  // read pointer
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || i_flush) begin
      rptr <= '0;
    end else if (pop) begin
      rptr <= rptr + 1'b1;
    end
  end
endmodule // cmb_fifo

// ----------------------------------------------------------------
// message buffer, standard mapping
// ----------------------------------------------------------------
// Contract
// [R01] 11-bit identifier, msb sent first
// [R02] smaller identifier wins arbitration
// [R03] ident_byte1 bits 7-5 hold identifier 2-0
// [R04] ident_byte1 bit 4 is remote flag
// [R05] ident_byte1 bit 3 is format flag
// [R06] eight payload bytes at indices 4 to B
// [R07] move only dlc-counted payload bytes
// [R08] remote frame: dlc sent, no bytes
// [R09] dlc 0 to 8 gives 0 to 8 bytes
// [R10] frame_length at index C
// [R11] ident_byte0 holds bits 10-3; bytes 2,3 unused
// [R12] dlc above 8 sent, payload capped eight
module cmb_msg_buffer #(
  parameter int ADDR_W = 7,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic o_tx_valid,
  output logic o_tx_bit,
  output logic o_tx_last,
  input wire logic i_tx_ready,
  input wire logic i_tx_bus_bit,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_last,
  output logic o_rx_ready
);
  // ----------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------
  // buffer bytes, indices 0 to C
  cmb_pkg::cmb_byte_type mem [0:12];
  // write channel holding
  logic aw_got;
  logic w_got;
  logic [4:0] aw_idx;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  // serializer
  cmb_pkg::cmb_tx_state_type state;
  logic [16:0] hdr_sh;
  logic [4:0] pos;
  logic [7:0] dsh;
  logic [2:0] bpos;
  logic [3:0] byte_n;
  logic [3:0] push_cnt;
  // status
  logic tx_done;
  logic arb_lost;
  logic rx_full;
  logic [3:0] rx_idx;

  // payload count from length code and remote flag
  function automatic logic [3:0] pay_count(input logic [3:0] dlc, input logic rtr);
    logic [3:0] n;
    n = 4'h0;
    // [R08] remote sends none
    if (rtr) begin
      n = 4'h0;
    // [R12] cap at eight
    end else if (dlc > `CMB_DLC_MAX) begin
      n = `CMB_DLC_MAX;
    // [R09] code equals count
    end else begin
      n = dlc;
    end
    return n;
  endfunction

  // ----------------------------------------------------------------
  // derived terms
  // ----------------------------------------------------------------
  logic [3:0] nbytes;
  logic wr_fire;
  logic wr_buf;
  logic ctrl_wr;
  logic start;
  logic clr;
  logic hs;
  logic arb_lose;
  logic hdr_end;
  logic last_byte;
  logic fin;
  logic f_push;
  logic f_ready;
  logic f_valid;
  logic f_pop;
  logic [7:0] f_data;
  logic rx_take;
  logic [3:0] rx_k;
  logic [3:0] rx_cnt;

  // [R07] length in force for both directions
  assign nbytes = pay_count(mem[12][3:0], mem[1][`CMB_ID1_RTR]);
  assign wr_fire = aw_got && w_got && !o_bvalid;
  // buffer is frozen while a frame uses it
  assign wr_buf = wr_fire && w_strb[0] && (aw_idx <= `CMB_IDX_LEN)
    && (state == cmb_pkg::TX_IDLE) && !o_rx_ready;
  assign ctrl_wr = wr_fire && w_strb[0] && (aw_idx == `CMB_IDX_CTRL);
  assign start = ctrl_wr && w_data[`CMB_CTRL_START]
    && (state == cmb_pkg::TX_IDLE) && !o_rx_ready;
  assign clr = ctrl_wr && w_data[`CMB_CTRL_CLR];
  assign hs = o_tx_valid && i_tx_ready;
  // [R02] recessive sent but dominant seen
  assign arb_lose = (state == cmb_pkg::TX_HDR) && hs && (pos < `CMB_ARB_BITS)
    && o_tx_bit && !i_tx_bus_bit;
  assign hdr_end = (state == cmb_pkg::TX_HDR) && hs && (pos == `CMB_HDR_LAST);
  assign last_byte = (byte_n == nbytes - 4'h1);
  assign fin = (hdr_end && (nbytes == 4'h0))
    || ((state == cmb_pkg::TX_DATA) && hs && (bpos == 3'h7) && last_byte);
  // [R07] push only counted bytes
  assign f_push = (state != cmb_pkg::TX_IDLE) && (push_cnt < nbytes);
  assign f_pop = (state == cmb_pkg::TX_WAIT) && f_valid;
  assign rx_take = i_rx_valid && o_rx_ready;
  assign rx_k = rx_idx - 4'h3;
  assign rx_cnt = pay_count(mem[12][3:0], mem[1][`CMB_ID1_RTR]);

  // ----------------------------------------------------------------
  // payload fifo between buffer and serializer
  // ----------------------------------------------------------------
  cmb_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_flush(arb_lose),
    .i_in_valid(f_push),
    .i_in_data(mem[4'(push_cnt + 4'h4)]),
    .o_in_ready(f_ready),
    .o_out_valid(f_valid),
    .o_out_data(f_data),
    .i_out_ready(f_pop)
  );

  // ----------------------------------------------------------------
  // axi write channels
  // ----------------------------------------------------------------
  // address: held until the response is taken
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      aw_got <= 1'b0;
      aw_idx <= 5'h00;
      o_awready <= 1'b0;
    end else if (o_awready && i_awvalid) begin
      aw_got <= 1'b1;
      aw_idx <= i_awaddr[6:2];
      o_awready <= 1'b0;
    end else if (o_bvalid && i_bready) begin
      aw_got <= 1'b0;
    end else begin
      o_awready <= !aw_got;
    end
  end

  // data: taken independently of address
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      w_got <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      o_wready <= 1'b0;
    end else if (o_wready && i_wvalid) begin
      w_got <= 1'b1;
      w_data <= i_wdata;
      w_strb <= i_wstrb;
      o_wready <= 1'b0;
    end else if (o_bvalid && i_bready) begin
      w_got <= 1'b0;
    end else begin
      o_wready <= !w_got;
    end
  end

  // response one cycle after both halves are held
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_bvalid <= 1'b0;
      o_bresp <= `CMB_RESP_OKAY;
    end else if (wr_fire) begin
      o_bvalid <= 1'b1;
      // unmapped index answers decode error
      if ((aw_idx <= `CMB_IDX_LEN) || (aw_idx == `CMB_IDX_CTRL)
          || (aw_idx == `CMB_IDX_STAT)) begin
        o_bresp <= `CMB_RESP_OKAY;
      end else begin
        o_bresp <= `CMB_RESP_DECERR;
      end
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= `CMB_RESP_OKAY;
    end else if (o_arready && i_arvalid) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rresp <= `CMB_RESP_OKAY;
      // [R06] [R10] buffer bytes in low lane
      if (i_araddr[6:2] <= `CMB_IDX_LEN) begin
        o_rdata <= {24'h00_0000, mem[4'(i_araddr[5:2])]};
      end else if (i_araddr[6:2] == `CMB_IDX_CTRL) begin
        o_rdata <= {30'h0000_0000, o_rx_ready, 1'b0};
      end else if (i_araddr[6:2] == `CMB_IDX_STAT) begin
        o_rdata <= {27'h000_0000, o_rx_ready, rx_full, arb_lost, tx_done,
          (state != cmb_pkg::TX_IDLE)};
      end else begin
        o_rdata <= 32'h0000_0000;
        o_rresp <= `CMB_RESP_DECERR;
      end
    end else if (o_rvalid) begin
      // hold until the master takes it
      o_rvalid <= !i_rready;
    end else begin
      o_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // buffer bytes: software writes and received frame
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      for (int i = 0; i < 13; i++) begin
        mem[i] <= `CMB_REG_RST;
      end
    end else if (rx_take) begin
      if (rx_idx == 4'h0) begin
        // [R11] identifier bits 10-3
        mem[0] <= i_rx_data;
      end else if (rx_idx == 4'h1) begin
        // [R03] [R04] [R05] low id, remote and format flags
        mem[1] <= i_rx_data;
      end else if (rx_idx == 4'h2) begin
        // [R10] length field, upper bits read zero
        mem[12] <= {4'h0, i_rx_data[3:0]};
      end else if (rx_k < rx_cnt) begin
        // [R07] bytes past the count are dropped
        mem[4'(rx_k + 4'h4)] <= i_rx_data;
      end
    end else if (wr_buf) begin
      if (aw_idx == `CMB_IDX_LEN) begin
        mem[12] <= {4'h0, w_data[3:0]};
      end else begin
        mem[aw_idx[3:0]] <= w_data[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // receive sequencing
  // ----------------------------------------------------------------
  // byte counter saturates so long frames never wrap onto the header
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rx_idx <= 4'h0;
      o_rx_ready <= 1'b0;
    end else if (rx_take && i_rx_last) begin
      o_rx_ready <= 1'b0;
    end else if (rx_take) begin
      rx_idx <= (rx_idx == 4'hF) ? rx_idx : rx_idx + 4'h1;
    end else if (ctrl_wr && w_data[`CMB_CTRL_ARM] && (state == cmb_pkg::TX_IDLE)) begin
      o_rx_ready <= 1'b1;
      rx_idx <= 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // sticky status, set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      tx_done <= 1'b0;
      arb_lost <= 1'b0;
      rx_full <= 1'b0;
    end else begin
      tx_done <= fin || (tx_done && !clr);
      arb_lost <= arb_lose || (arb_lost && !clr);
      rx_full <= (rx_take && i_rx_last) || (rx_full && !clr);
    end
  end

  // ----------------------------------------------------------------
  // payload loader
  // ----------------------------------------------------------------
  // stalls whenever the fifo is full
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || start) begin
      push_cnt <= 4'h0;
    end else if (f_push && f_ready) begin
      push_cnt <= push_cnt + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // bit serializer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state <= cmb_pkg::TX_IDLE;
      o_tx_valid <= 1'b0;
      o_tx_bit <= 1'b0;
      o_tx_last <= 1'b0;
      hdr_sh <= 17'h0_0000;
      pos <= 5'h00;
      dsh <= 8'h00;
      bpos <= 3'h0;
      byte_n <= 4'h0;
    end else begin
      case (state)
        cmb_pkg::TX_IDLE: begin
          if (start) begin
            // [R01] [R11] frame_ident_bits, rtr, ide, dlc; bytes 2,3 unused
            // [R08] [R12] dlc goes out as programmed
            hdr_sh <= {mem[0], mem[1][7:3], mem[12][3:0]};
            o_tx_bit <= mem[0][7];
            o_tx_valid <= 1'b1;
            pos <= 5'h00;
            byte_n <= 4'h0;
            state <= cmb_pkg::TX_HDR;
          end
        end
        cmb_pkg::TX_HDR: begin
          // [R02] losing node backs off at once
          if (arb_lose) begin
            o_tx_valid <= 1'b0;
            state <= cmb_pkg::TX_IDLE;
          end else if (hdr_end) begin
            o_tx_valid <= 1'b0;
            o_tx_last <= 1'b0;
            // [R08] no data after a remote header
            state <= (nbytes == 4'h0) ? cmb_pkg::TX_IDLE : cmb_pkg::TX_WAIT;
          end else if (hs) begin
            // [R01] msb first shift
            o_tx_bit <= hdr_sh[15];
            hdr_sh <= {hdr_sh[15:0], 1'b0};
            pos <= pos + 5'h01;
            // flag must ride on the final header bit, the one at the last position, only when no payload bytes follow
            o_tx_last <= (pos == `CMB_HDR_LAST - 5'h01) && (nbytes == 4'h0);
          end
        end
        cmb_pkg::TX_WAIT: begin
          // valid stays low, so no gap bits go out, while the fifo is empty
          if (f_valid) begin
            o_tx_bit <= f_data[7];
            dsh <= f_data;
            bpos <= 3'h0;
            o_tx_valid <= 1'b1;
            o_tx_last <= 1'b0;
            state <= cmb_pkg::TX_DATA;
          end
        end
        cmb_pkg::TX_DATA: begin
          if (hs) begin
            if (bpos == 3'h7) begin
              o_tx_valid <= 1'b0;
              o_tx_last <= 1'b0;
              byte_n <= byte_n + 4'h1;
              // [R07] stop after the counted bytes
              state <= last_byte ? cmb_pkg::TX_IDLE : cmb_pkg::TX_WAIT;
            end else begin
              o_tx_bit <= dsh[6];
              dsh <= {dsh[6:0], 1'b0};
              bpos <= bpos + 3'h1;
              o_tx_last <= (bpos == 3'h6) && last_byte;
            end
          end
        end
        default: begin
          state <= cmb_pkg::TX_IDLE;
        end
      endcase
    end
  end
endmodule // cmb_msg_buffer

`default_nettype wire

// ### tb/cmb_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
// engine stand-in: takes tx bits, can stall, can force a dominant level
module cmb_engine_model (
  input wire logic i_clk_sys, i_srst, i_clear, i_slow,
  input wire logic i_tx_valid, i_tx_bit, i_tx_last,
  input wire logic [7:0] i_lose_at,
  output logic o_tx_ready, o_tx_bus_bit,
  output logic [95:0] o_bits,
  output logic [7:0] o_count,
  output logic [7:0] o_last_at // bit number, from one, that carried the last flag
);
  logic hs; // bit taken at this edge
  assign hs = i_tx_valid && o_tx_ready;
  // another node drives dominant at the chosen bit index
  assign o_tx_bus_bit = (o_count == i_lose_at) ? 1'h0 : i_tx_bit;
  // slow mode takes a bit only every other cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) o_tx_ready <= 1'h0;
    else o_tx_ready <= !i_slow || !o_tx_ready;
  end
  // record taken bits, each shifted in at bit 0, so the last bit ends up at the bottom
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || i_clear) begin
      o_bits <= '0;
      o_count <= '0;
      o_last_at <= '0;
    end else if (hs) begin
      o_bits <= {o_bits[94:0], i_tx_bit};
      o_count <= o_count + 8'h01;
      if (i_tx_last) o_last_at <= o_count + 8'h01;
    end
  end
endmodule // cmb_engine_model
`default_nettype wire

// ### tb/cmb_msg_buffer_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// port checks
// ----------------------------------------------------------------
module cmb_msg_buffer_checker #(parameter int ADDR_W = 7) (
  input wire logic i_clk_sys, i_srst,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid,
  input wire logic i_arvalid, o_arready, o_rvalid,
  input wire logic [1:0] o_rresp,
  input wire logic o_tx_valid, o_tx_bit, o_tx_last, i_tx_ready, i_tx_bus_bit,
  input wire logic i_rx_valid, i_rx_last, o_rx_ready
);
  logic hs; // tx bit handshake
  logic [6:0] nbit; // bits taken so far in this frame
  assign hs = o_tx_valid && i_tx_ready;
  // a loss or the final bit starts a new count
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || (hs && (o_tx_last || (nbit < 7'h0C && o_tx_bit && !i_tx_bus_bit))))
      nbit <= '0;
    else if (hs) nbit <= nbit + 7'h01;
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready
    |-> ##2 o_bvalid) else $error("write answer missing");
  a_write_closed: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write ready during answer");
  a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer missing");
  a_read_closed: assert property (o_rvalid |-> !o_arready)
    else $error("read ready during answer");
  a_unmapped_err: assert property (i_arvalid && o_arready && i_araddr[ADDR_W-1:2] > 5'h11
    |=> o_rresp == 2'h3) else $error("unmapped read not refused");
  a_bit_holds: assert property (o_tx_valid && !i_tx_ready
    |=> o_tx_valid && $stable(o_tx_bit)) else $error("tx bit changed before taken");
  a_arb_drop: assert property (hs && nbit < 7'h0C && o_tx_bit && !i_tx_bus_bit
    |=> !o_tx_valid) else $error("lost arbitration not ended");
  a_last_count: assert property (hs && o_tx_last
    |-> nbit >= 7'h10 && nbit <= 7'h50 && nbit[2:0] == 3'h0) else $error("frame length wrong");
  a_last_ends: assert property (hs && o_tx_last |=> !o_tx_valid)
    else $error("tx runs past last bit");
  a_rx_done: assert property (i_rx_valid && o_rx_ready && i_rx_last |=> !o_rx_ready)
    else $error("rx still armed after last byte");
  c_tx_frame: cover property (hs && o_tx_last);
  c_arb_lost: cover property (hs && o_tx_bit && !i_tx_bus_bit);
  c_rx_frame: cover property (i_rx_valid && o_rx_ready && i_rx_last);
endmodule // cmb_msg_buffer_checker
bind cmb_msg_buffer cmb_msg_buffer_checker #(.ADDR_W(ADDR_W)) u_chk (.i_clk_sys(i_clk_sys),
  .i_srst(i_srst), .i_araddr(i_araddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
  .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid), .i_arvalid(i_arvalid),
  .o_arready(o_arready), .o_rvalid(o_rvalid), .o_rresp(o_rresp), .o_tx_valid(o_tx_valid),
  .o_tx_bit(o_tx_bit), .o_tx_last(o_tx_last), .i_tx_ready(i_tx_ready),
  .i_tx_bus_bit(i_tx_bus_bit), .i_rx_valid(i_rx_valid), .i_rx_last(i_rx_last),
  .o_rx_ready(o_rx_ready));
`default_nettype wire

// ### tb/cmb_msg_buffer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cmb_msg_buffer_tb;
  logic clk = 1'h0, srst = 1'h1, awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0;
  logic rready = 1'h0, rxv = 1'h0, rxl = 1'h0, m_clear = 1'h0, m_slow = 1'h0;
  logic [6:0] awaddr = 7'h00, araddr = 7'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic awready, wready, bvalid, arready, rvalid, txv, txb, txl, txr, busb, rxr;
  logic [7:0] rxd = 8'h00, lose = 8'hFF, m_count, m_last;
  logic [95:0] m_bits;
  // payload pattern, then rx bytes, their read-back places and values
  logic [7:0] pay [8] = '{8'h3C, 8'hC3, 8'h5A, 8'hA5, 8'h01, 8'h80, 8'h7E, 8'hE7};
  logic [7:0] rxb [7] = '{8'h12, 8'h48, 8'h03, 8'h11, 8'h22, 8'h33, 8'h44};
  logic [4:0] ridx [7] = '{5'h00, 5'h01, 5'h0C, 5'h04, 5'h05, 5'h06, 5'h07};
  logic [7:0] rexp [7] = '{8'h12, 8'h48, 8'h03, 8'h11, 8'h22, 8'h33, 8'hA5};
  int errors = 0;
  int check_count = 0;
  always #4 clk = ~clk;
  cmb_msg_buffer DUT (.i_clk_sys(clk), .i_srst(srst), .i_awaddr(awaddr), .i_awvalid(awv),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wv), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arv), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
    .o_rvalid(rvalid), .i_rready(rready), .o_tx_valid(txv), .o_tx_bit(txb),
    .o_tx_last(txl), .i_tx_ready(txr), .i_tx_bus_bit(busb), .i_rx_valid(rxv),
    .i_rx_data(rxd), .i_rx_last(rxl), .o_rx_ready(rxr));
  cmb_engine_model u_eng (.i_clk_sys(clk), .i_srst(srst), .i_clear(m_clear),
    .i_slow(m_slow), .i_tx_valid(txv), .i_tx_bit(txb), .i_tx_last(txl), .i_lose_at(lose),
    .o_tx_ready(txr), .o_tx_bus_bit(busb), .o_bits(m_bits), .o_count(m_count),
    .o_last_at(m_last));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic give_up();
    errors++;
    $display("ERROR %0t: wait ran out", $time);
    wrap_up();
  endtask
  task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  // one write; address and data offered together, response awaited
  task automatic axi_wr(input logic [4:0] idx, input logic [31:0] v, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= {idx, 2'h0};
    wdata <= v;
    awv <= 1'h1;
    wv <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awv <= 1'h0;
      if (wready) wv <= 1'h0;
    end while (bvalid !== 1'h1 && n < 100);
    bready <= 1'h0;
    if (n >= 100) give_up();
    chk(bresp, er, "bresp");
    @(posedge clk);
  endtask
  // one read into d and r
  task automatic axi_rd(input logic [4:0] idx);
    int n;
    n = 0;
    araddr <= {idx, 2'h0};
    arv <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arv <= 1'h0;
    end while (rvalid !== 1'h1 && n < 100);
    rready <= 1'h0;
    d = rdata;
    r = rresp;
    if (n >= 100) give_up();
    @(posedge clk);
  endtask
  // poll status until the transmitter is idle
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      axi_rd(5'h11);
      n++;
    end while (d[0] !== 1'h0 && n < 200);
    if (n >= 200) give_up();
  endtask
  // expected wire bits: header then payload, msb first
  function automatic logic [95:0] frame(input logic [10:0] id, input logic rtr, ide,
      input logic [3:0] dlc, input int nb);
    logic [95:0] f;
    f = 96'({id, rtr, ide, dlc});
    for (int i = 0; i < nb; i++) f = {f[87:0], pay[i]};
    return f;
  endfunction
  task automatic run_tx(input logic [10:0] id, input logic rtr, ide, input logic [3:0] dlc,
      input logic slow, input logic [7:0] la);
    int nb;
    int nt;
    nb = rtr ? 0 : ((dlc > 4'h8) ? 8 : int'(dlc));
    nt = (la == 8'hFF) ? 17 + 8 * nb : int'(la) + 1;
    m_slow <= slow;
    lose <= la;
    m_clear <= 1'h1;
    axi_wr(5'h00, 32'(id[10:3]), 2'h0);
    m_clear <= 1'h0;
    axi_wr(5'h01, 32'({id[2:0], rtr, ide, 3'h0}), 2'h0);
    axi_wr(5'h0C, 32'(dlc), 2'h0);
    axi_wr(5'h10, 32'h0000_0004, 2'h0);
    axi_wr(5'h10, 32'h0000_0001, 2'h0);
    wait_idle();
    chk(m_count, 96'(nt), "bit count");
    chk(m_last, (la == 8'hFF) ? 96'(nt) : 96'h0, "last flag");
    chk(m_bits, frame(id, rtr, ide, dlc, nb) >> (17 + 8 * nb - nt), "wire bits");
    chk(d, (la == 8'hFF) ? 32'h0000_0002 : 32'h0000_0004, "status");
    axi_rd(5'h01);
    chk(d, 32'({id[2:0], rtr, ide, 3'h0}), "ident_byte1");
    $display("test tx id %h done", id);
  endtask
  // one rx byte, held until the buffer is armed; line toggles while idle
  task automatic rx_send(input logic [7:0] b, input logic last);
    int n;
    n = 0;
    rxv <= 1'h1;
    rxd <= b;
    rxl <= last;
    do begin
      @(posedge clk);
      n++;
    end while (rxr !== 1'h1 && n < 50);
    rxv <= 1'h0;
    rxd <= ~b;
    rxl <= 1'h0;
    if (n >= 50) give_up();
    @(posedge clk);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'h0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 13; i++) begin
      axi_rd(5'(i));
      chk(d, 32'h0000_0000, "reset value");
    end
    axi_wr(5'h0C, 32'h0000_00FF, 2'h0);
    axi_rd(5'h0C);
    chk(d, 32'h0000_000F, "frame_length");
    axi_wr(5'h1F, 32'h0000_0055, 2'h3);
    axi_rd(5'h1F);
    chk(r, 2'h3, "unmapped resp");
    for (int i = 0; i < 8; i++) begin
      axi_wr(5'(i + 4), 32'(pay[i]), 2'h0);
      axi_rd(5'(i + 4));
      chk(d, 32'(pay[i]), "payload");
    end
    $display("test registers done");
    run_tx(11'h5A3, 1'h0, 1'h0, 4'h2, 1'h0, 8'hFF);
    run_tx(11'h400, 1'h0, 1'h0, 4'h0, 1'h0, 8'hFF);
    run_tx(11'h001, 1'h0, 1'h0, 4'h8, 1'h1, 8'hFF);
    run_tx(11'h0F0, 1'h1, 1'h1, 4'h9, 1'h1, 8'hFF);
    run_tx(11'h2C7, 1'h0, 1'h0, 4'hC, 1'h1, 8'hFF);
    run_tx(11'h7FF, 1'h0, 1'h0, 4'h0, 1'h0, 8'h03);
    axi_wr(5'h10, 32'h0000_0004, 2'h0);
    axi_wr(5'h10, 32'h0000_0002, 2'h0);
    foreach (rxb[i]) rx_send(rxb[i], i == 6);
    foreach (ridx[i]) begin
      axi_rd(ridx[i]);
      chk(d, 32'(rexp[i]), "rx byte");
    end
    axi_rd(5'h11);
    chk(d, 32'h0000_0008, "rx status");
    $display("test rx done");
    wrap_up();
  end
endmodule // cmb_msg_buffer_tb
`default_nettype wire
